// *** design/sbap_chk.sv ***
// Purpose: Address parity check and error window of every strobe
// Assumes: Bus pins sampled on the rising clock edge
// Notes: Window falls a fixed number of cycles after the strobe
module sbap_chk
   import sbap_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   sbap_chk_if.chk bus
);

   sbap_chk_st_t r;
   sbap_chk_st_t next_r;
   logic mismatch;

   always_comb begin
      next_r = r;
      mismatch = (sbap_addr_par(bus.addr_n) != bus.par_n);
      next_r.pipe_v = {r.pipe_v[`SBAP_ADDR_PARITY_ERR_N_DLY-2:0], ~bus.strobe_n};
      next_r.pipe_e = {r.pipe_e[`SBAP_ADDR_PARITY_ERR_N_DLY-2:0],
                       ~bus.strobe_n & mismatch};
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign bus.window = r.pipe_v[`SBAP_ADDR_PARITY_ERR_N_DLY-1];
   assign bus.addr_parity_err_n_drive = r.pipe_e[`SBAP_ADDR_PARITY_ERR_N_DLY-1] & bus.drv_en;
   assign bus.abort = bus.window & ~bus.addr_parity_err_n_n & bus.obs_en;

endmodule

// *** design/sbap_chk_if.sv ***
// Purpose: Carrier between the request engine and the parity checker
// Assumes: One clock domain
// Notes: Levels are pin levels of the shared bus
interface sbap_chk_if;
   import sbap_pkg::*;
   logic strobe_n;
   sbap_addr_t addr_n;
   logic [1:0] par_n;
   logic addr_parity_err_n_n;
   logic obs_en;
   logic drv_en;
   logic window;
   logic addr_parity_err_n_drive;
   logic abort;

   modport core (
      output strobe_n, addr_n, par_n, addr_parity_err_n_n, obs_en, drv_en,
      input window, addr_parity_err_n_drive, abort
   );
   modport chk (
      input strobe_n, addr_n, par_n, addr_parity_err_n_n, obs_en, drv_en,
      output window, addr_parity_err_n_drive, abort
   );
endinterface

// *** design/sbap_defines.svh ***
// Purpose: Constants of the system bus address phase unit
// Assumes: Address lines 35:3, bus pins at electrical (active-low) level
// Notes: Config bit positions and error window are local choices
`ifndef SBAP_DEFINES_SVH
`define SBAP_DEFINES_SVH

`define SBAP_ADDR_MSB 35
`define SBAP_ADDR_LSB 3
`define SBAP_HI_LSB 24
`define SBAP_LO_MSB 23
`define SBAP_A20_BIT 20
`define SBAP_REQ_W 5
`define SBAP_CFG_ADDR_PARITY_ERR_N_OBS 5
`define SBAP_CFG_ADDR_PARITY_ERR_N_DRV 4
`define SBAP_CFG_RST 33'h0
`define SBAP_ADDR_PARITY_ERR_N_DLY 3

`endif

// *** design/sbap_pkg.sv ***
// Purpose: Types and parity helper of the address phase unit
// Assumes: sbap_defines.svh holds every number
// Notes: Parity works on pin levels, not on logical values
`include "sbap_defines.svh"

package sbap_pkg;

   typedef logic [`SBAP_ADDR_MSB:`SBAP_ADDR_LSB] sbap_addr_t;
   typedef logic [`SBAP_REQ_W-1:0] sbap_type_t;

   typedef enum logic [3:0] {
      SBAP_IDLE = 4'b0001,
      SBAP_ADDR = 4'b0010,
      SBAP_TYPE = 4'b0100,
      SBAP_WAIT = 4'b1000
   } sbap_state_t;

   typedef struct packed {
      sbap_state_t st;
      logic rst_n_q;
      sbap_addr_t cfg;
      logic cfg_valid;
      sbap_addr_t addr_out;
      logic addr_oe;
      logic strobe_oe;
      sbap_type_t type_out;
      logic type_oe;
      logic [1:0] par_out;
      logic par_oe;
      logic rp_out;
      sbap_addr_t ext_hold;
      sbap_addr_t lookup;
      logic done;
      logic abort;
      logic snoop_valid;
      sbap_addr_t snoop_addr;
   } sbap_core_t;

   typedef struct packed {
      logic [`SBAP_ADDR_PARITY_ERR_N_DLY-1:0] pipe_v;
      logic [`SBAP_ADDR_PARITY_ERR_N_DLY-1:0] pipe_e;
   } sbap_chk_st_t;

   // Level high when an even number of covered pins are low
   function automatic logic [1:0] sbap_addr_par(input sbap_addr_t lvl);
      logic [1:0] p;
      p[1] = ~(^(~lvl[`SBAP_ADDR_MSB:`SBAP_HI_LSB]));
      p[0] = ~(^(~lvl[`SBAP_LO_MSB:`SBAP_ADDR_LSB]));
      return p;
   endfunction

endpackage

// *** design/sbap_top.sv ***
// Purpose: Request and address phase of the shared system bus
// Assumes: Bus inputs synchronous to ref_clk_i; bus arbitration is done
// Notes: Pins are carried as in, out and output enable at pin level
//        A later bus reset release reloads the configuration
//
// Function
// - While the mask input is high, address bit 20 is cleared for lookup and bus.
// - Lines 35:3 carry the address with the strobe and type info after it.
// - The high parity line covers bits 35:24 and the low one bits 23:3.
// - A parity line is high when an even number of its pins are low.
// - The initiator drives parity with strobe, address, type and its parity.
// - Every strobe starts parity checking, decode and snoop of the request; snoop here needs bus reset released.
// - With observation enabled, a valid error assertion aborts the request.
// - Each agent can both drive and observe the shared parity error pin.
// - On release of the bus reset the address lines give the configuration.
// - Single-ended clocking drives and samples on the rising clock edge.
// - Differential clocking drives and samples at the clock crossing; this unit has single-ended rising-edge clocking only.
module sbap_top
   import sbap_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic bus_reset_n_i,
   input wire logic addr20_mask_in_i,
   input wire logic req_valid_i,
   input wire sbap_addr_t req_addr_i,
   input wire sbap_addr_t req_ext_i,
   input wire sbap_type_t req_type_i,
   output logic req_ready_o,
   output sbap_addr_t lookup_addr_o,
   output logic txn_done_o,
   output logic txn_abort_o,
   output logic snoop_valid_o,
   output sbap_addr_t snoop_addr_o,
   output sbap_addr_t cfg_o,
   output logic cfg_valid_o,
   input wire sbap_addr_t addr_n_i,
   output sbap_addr_t addr_n_o,
   output logic addr_n_oe_o,
   input wire logic addr_strobe_n_i,
   output logic addr_strobe_n_o,
   output logic addr_strobe_n_oe_o,
   input wire logic [1:0] addr_parity_n_i,
   output logic [1:0] addr_parity_n_o,
   output logic addr_parity_n_oe_o,
   input wire sbap_type_t req_type_n_i,
   output sbap_type_t req_type_n_o,
   output logic req_type_n_oe_o,
   input wire logic request_parity_n_i,
   output logic request_parity_n_o,
   output logic request_parity_n_oe_o,
   input wire logic addr_parity_err_n_i,
   output logic addr_parity_err_n_o,
   output logic addr_parity_err_n_oe_o
);

   sbap_core_t r;
   sbap_core_t next_r;
   sbap_chk_if chk_bus ();
   sbap_addr_t masked;
   sbap_addr_t lvl;
   logic rst_rise;
   logic start;

   // Check runs on every strobe, own or foreign
   sbap_chk u_chk (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .bus(chk_bus.chk)
   );

   assign chk_bus.strobe_n = addr_strobe_n_i;
   assign chk_bus.addr_n = addr_n_i;
   assign chk_bus.par_n = addr_parity_n_i;
   assign chk_bus.addr_parity_err_n_n = addr_parity_err_n_i;
   // Disabled observation leaves it to others
   assign chk_bus.obs_en = r.cfg_valid & r.cfg[`SBAP_CFG_ADDR_PARITY_ERR_N_OBS];
   assign chk_bus.drv_en = r.cfg_valid & r.cfg[`SBAP_CFG_ADDR_PARITY_ERR_N_DRV];

   assign rst_rise = bus_reset_n_i & ~r.rst_n_q;

   assign start = req_valid_i & req_ready_o;

   always_comb begin
      // Pulses clear each cycle, other fields hold
      next_r = r;
      next_r.rst_n_q = bus_reset_n_i;
      next_r.done = 1'b0;
      next_r.abort = 1'b0;
      masked = req_addr_i;
      if (addr20_mask_in_i) begin
         masked[`SBAP_A20_BIT] = 1'b0;
      end
      lvl = ~masked;
      next_r.lookup = masked;
      if (rst_rise) begin
         next_r.cfg = ~addr_n_i;
         next_r.cfg_valid = 1'b1;
      end
      next_r.snoop_valid = ~addr_strobe_n_i & bus_reset_n_i;
      if (~addr_strobe_n_i) begin
         next_r.snoop_addr = ~addr_n_i;
      end
      case (r.st)
         SBAP_IDLE: begin
            next_r.addr_oe = 1'b0;
            next_r.strobe_oe = 1'b0;
            next_r.type_oe = 1'b0;
            next_r.par_oe = 1'b0;
            if (start) begin
               next_r.st = SBAP_ADDR;
               next_r.addr_out = lvl;
               next_r.addr_oe = 1'b1;
               next_r.strobe_oe = 1'b1;
               next_r.type_out = ~req_type_i;
               next_r.type_oe = 1'b1;
               next_r.par_out = sbap_addr_par(lvl);
               next_r.par_oe = 1'b1;
               next_r.rp_out = ~(^{1'b1, req_type_i});
               next_r.ext_hold = req_ext_i;
            end
         end
         SBAP_ADDR: begin
            next_r.st = SBAP_TYPE;
            next_r.strobe_oe = 1'b0;
            next_r.addr_out = ~r.ext_hold;
            // Type cycle carries no parity
            next_r.par_oe = 1'b0;
         end
         SBAP_TYPE: begin
            next_r.st = SBAP_WAIT;
            next_r.addr_oe = 1'b0;
            next_r.type_oe = 1'b0;
         end
         SBAP_WAIT: begin
            if (chk_bus.window) begin
               next_r.st = SBAP_IDLE;
               next_r.done = ~chk_bus.abort;
            end
         end
         default: begin
            next_r.st = SBAP_IDLE;
         end
      endcase
      // Limitation: an error for a foreign strobe aborts as well
      // Abort on observed error
      if (chk_bus.abort && r.st != SBAP_IDLE) begin
         next_r.st = SBAP_IDLE;
         next_r.abort = 1'b1;
         next_r.done = 1'b0;
         next_r.addr_oe = 1'b0;
         next_r.strobe_oe = 1'b0;
         next_r.type_oe = 1'b0;
         next_r.par_oe = 1'b0;
      end
      // Bus reset drops every drive except the parity error pin on the next clock edge
      if (!bus_reset_n_i) begin
         next_r.st = SBAP_IDLE;
         next_r.addr_oe = 1'b0;
         next_r.strobe_oe = 1'b0;
         next_r.type_oe = 1'b0;
         next_r.par_oe = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         r <= '0;
         r.st <= SBAP_IDLE;
         // High, so no false release edge follows reset
         r.rst_n_q <= 1'b1;
         r.cfg <= `SBAP_CFG_RST;
      end else begin
         r <= next_r;
      end
   end

   // Waiting for an idle strobe avoids colliding with another initiator
   assign req_ready_o = (r.st == SBAP_IDLE) & r.cfg_valid &
                        bus_reset_n_i & addr_strobe_n_i;
   assign lookup_addr_o = r.lookup;
   assign txn_done_o = r.done;
   assign txn_abort_o = r.abort;
   assign snoop_valid_o = r.snoop_valid;
   assign snoop_addr_o = r.snoop_addr;
   assign cfg_o = r.cfg;
   assign cfg_valid_o = r.cfg_valid;
   assign addr_n_o = r.addr_out;
   assign addr_n_oe_o = r.addr_oe;
   // Strobe and error pins only pull low; the enable carries the level
   assign addr_strobe_n_o = 1'b0;
   assign addr_strobe_n_oe_o = r.strobe_oe;
   assign addr_parity_n_o = r.par_out;
   assign addr_parity_n_oe_o = r.par_oe;
   assign req_type_n_o = r.type_out;
   assign req_type_n_oe_o = r.type_oe;
   assign request_parity_n_o = r.rp_out;
   assign request_parity_n_oe_o = r.strobe_oe;
   assign addr_parity_err_n_o = 1'b0;
   assign addr_parity_err_n_oe_o = chk_bus.addr_parity_err_n_drive;

endmodule

// *** test/sbap_far.sv ***
// Purpose: Other bus agent and bus reset source
// Assumes: Released lines float high through termination
// Notes: Drives shortly after the rising edge only
module sbap_far
   import sbap_pkg::*;
(
   input wire logic ref_clk_i,
   output logic rst_n_o,
   output sbap_addr_t addr_n_o,
   output logic strobe_n_o,
   output logic [1:0] par_n_o,
   output logic err_n_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      {strobe_n_o, err_n_o, par_n_o, addr_n_o} = '1;
      rst_n_o = 1'h0;
   end
   task automatic boot(input sbap_addr_t cfg);
      rst_n_o = 1'h0;
      addr_n_o = ~cfg;
      @(posedge ref_clk_i) #1 rst_n_o = 1'h1;
      @(posedge ref_clk_i) #1 addr_n_o = '1;
   endtask
   task automatic send(input sbap_addr_t a, input logic bad);
      addr_n_o = ~a;
      strobe_n_o = 1'h0;
      par_n_o = {~^a[35:24], ~^a[23:3] ^ bad};
      @(posedge ref_clk_i) #1 strobe_n_o = 1'h1;
      par_n_o = 2'h3;
      addr_n_o = '1;
   endtask
   task automatic pulse_err();
      err_n_o = 1'h0;
      @(posedge ref_clk_i) #1 err_n_o = 1'h1;
   endtask
endmodule

// *** test/sbap_top_chk.sv ***
// Purpose: Port checks of the address phase unit
// Assumes: Pins at electrical level, low is asserted
// Notes: Parity model kept apart from the design's helper
module sbap_top_chk
   import sbap_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic bus_reset_n_i,
   input wire logic addr20_mask_in_i,
   input wire logic txn_abort_o,
   input wire logic snoop_valid_o,
   input wire sbap_addr_t snoop_addr_o,
   input wire sbap_addr_t lookup_addr_o,
   input wire sbap_addr_t cfg_o,
   input wire logic cfg_valid_o,
   input wire sbap_addr_t addr_n_i,
   input wire sbap_addr_t addr_n_o,
   input wire logic addr_n_oe_o,
   input wire logic addr_strobe_n_i,
   input wire logic addr_strobe_n_oe_o,
   input wire logic [1:0] addr_parity_n_i,
   input wire logic [1:0] addr_parity_n_o,
   input wire logic addr_parity_n_oe_o,
   input wire logic req_type_n_oe_o,
   input wire logic request_parity_n_oe_o,
   input wire logic addr_parity_err_n_i,
   input wire logic addr_parity_err_n_oe_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   function automatic logic [1:0] par_of(input sbap_addr_t v);
      return {~^(~v[35:24]), ~^(~v[23:3])};
   endfunction
   logic bad;
   assign bad = !addr_strobe_n_i && bus_reset_n_i && cfg_o[4] &&
      addr_parity_n_i != par_of(addr_n_i);
   property p_mask; addr20_mask_in_i |=> !lookup_addr_o[20]; endproperty
   a_mask: assert property (p_mask) else $error("bit 20 not masked");
   property p_type;
      $rose(addr_strobe_n_oe_o) |=> addr_n_oe_o && !addr_strobe_n_oe_o;
   endproperty
   a_type: assert property (p_type) else $error("no type cycle");
   property p_par;
      addr_parity_n_oe_o |-> addr_parity_n_o == par_of(addr_n_o);
   endproperty
   a_par: assert property (p_par) else $error("bad parity out");
   property p_with;
      addr_strobe_n_oe_o |-> addr_n_oe_o && addr_parity_n_oe_o &&
         req_type_n_oe_o && request_parity_n_oe_o;
   endproperty
   a_with: assert property (p_with) else $error("lines not with strobe");
   property p_snoop;
      !addr_strobe_n_i && bus_reset_n_i |=>
         snoop_valid_o && snoop_addr_o == ~$past(addr_n_i);
   endproperty
   a_snoop: assert property (p_snoop) else $error("strobe not seen");
   property p_abort;
      cfg_o[5] && !addr_parity_err_n_i && $past(addr_strobe_n_oe_o, 3)
         |=> txn_abort_o;
   endproperty
   a_abort: assert property (p_abort) else $error("no abort");
   property p_err;
      bad |-> ##3 addr_parity_err_n_oe_o ##1 !addr_parity_err_n_oe_o;
   endproperty
   a_err: assert property (p_err) else $error("error slot wrong");
   property p_drv; addr_parity_err_n_oe_o |-> $past(bad, 3); endproperty
   a_drv: assert property (p_drv) else $error("stray error drive");
   property p_cfg;
      $rose(bus_reset_n_i) |=> cfg_valid_o && cfg_o == ~$past(addr_n_i);
   endproperty
   a_cfg: assert property (p_cfg) else $error("config not taken");
   c_abort: cover property (txn_abort_o);
   c_err: cover property (addr_parity_err_n_oe_o);
   c_snoop: cover property (snoop_valid_o && !addr_strobe_n_oe_o);
endmodule
bind sbap_top sbap_top_chk chk (.*);

// *** test/testbench.sv ***
// Purpose: Self-checking bench of the address phase unit
// Assumes: Bus lines are wired-AND with pull-ups
// Notes: Ports joined by matching names
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
   err_count++; $display("wrong value at %0t: %h vs %h", $time, a, b); \
   end end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import sbap_pkg::*;
   logic ref_clk_i = 1'h0;
   logic sys_rst_i = 1'h1;
   logic addr20_mask_in_i = 1'h0;
   logic req_valid_i = 1'h0;
   sbap_addr_t req_addr_i = 33'h123f74678;
   sbap_addr_t req_ext_i = 33'h000001c5a;
   sbap_type_t req_type_i = 5'h0a;
   logic req_ready_o, txn_done_o, txn_abort_o, snoop_valid_o, cfg_valid_o;
   sbap_addr_t lookup_addr_o, snoop_addr_o, cfg_o, addr_n_o;
   logic addr_n_oe_o, addr_strobe_n_o, addr_strobe_n_oe_o;
   logic [1:0] addr_parity_n_o;
   logic addr_parity_n_oe_o, req_type_n_oe_o;
   sbap_type_t req_type_n_o;
   logic request_parity_n_o, request_parity_n_oe_o;
   logic addr_parity_err_n_o, addr_parity_err_n_oe_o;
   wire logic bus_reset_n_i, f_s, f_e;
   wire sbap_addr_t f_a;
   wire logic [1:0] f_p;
   wire sbap_addr_t addr_n_i = (addr_n_oe_o ? addr_n_o : '1) & f_a;
   wire logic addr_strobe_n_i =
      (addr_strobe_n_oe_o ? addr_strobe_n_o : 1'h1) & f_s;
   wire logic [1:0] addr_parity_n_i =
      (addr_parity_n_oe_o ? addr_parity_n_o : 2'h3) & f_p;
   wire sbap_type_t req_type_n_i = req_type_n_oe_o ? req_type_n_o : '1;
   wire logic request_parity_n_i =
      request_parity_n_oe_o ? request_parity_n_o : 1'h1;
   wire logic addr_parity_err_n_i =
      (addr_parity_err_n_oe_o ? addr_parity_err_n_o : 1'h1) & f_e;
   int err_count = 0;
   int total_checks = 0;
   sbap_top uut (.*);
   sbap_far far (.ref_clk_i(ref_clk_i), .rst_n_o(bus_reset_n_i),
      .addr_n_o(f_a), .strobe_n_o(f_s), .par_n_o(f_p), .err_n_o(f_e));
   always #12.5 ref_clk_i = ~ref_clk_i;
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic t_boot(input sbap_addr_t cfg);
      far.boot(cfg);
      `CHK(cfg_o, cfg)
      `CHK(cfg_valid_o, 1'h1)
   endtask
   task automatic t_own(input logic m, input logic err, input logic obs);
      sbap_addr_t exp;
      int n;
      exp = req_addr_i;
      exp[20] = exp[20] & !m;
      addr20_mask_in_i = m;
      req_valid_i = 1'h1;
      for (n = 0; n < 20 && req_ready_o !== 1'h1; n++) tick(1);
      `CHK(req_ready_o, 1'h1)
      tick(1);
      req_valid_i = 1'h0;
      `CHK(lookup_addr_o, exp)
      `CHK(addr_n_o, ~exp)
      `CHK(addr_parity_n_o, {~^exp[35:24], ~^exp[23:3]})
      `CHK(addr_strobe_n_oe_o & addr_parity_n_oe_o, 1'h1)
      `CHK(addr_strobe_n_i, 1'h0)
      `CHK(req_type_n_o, ~req_type_i)
      `CHK(request_parity_n_o, 1'h0)
      tick(1);
      `CHK(addr_n_o, ~req_ext_i)
      `CHK(addr_strobe_n_oe_o, 1'h0)
      `CHK(addr_n_oe_o & req_type_n_oe_o, 1'h1)
      if (err) begin
         tick(2);
         far.pulse_err();
      end
      for (n = 0; n < 10 && txn_done_o !== 1'h1 &&
         txn_abort_o !== 1'h1; n++) tick(1);
      if (!err) `CHK(n, 3)
      `CHK(txn_abort_o, err & obs)
      `CHK(txn_done_o, !(err & obs))
      addr20_mask_in_i = 1'h0;
   endtask
   task automatic t_snoop(input logic bad);
      far.send(33'h087654320, bad);
      `CHK(snoop_valid_o, 1'h1)
      `CHK(snoop_addr_o, 33'h087654320)
      tick(2);
      `CHK(addr_parity_err_n_oe_o, bad)
      `CHK(addr_parity_err_n_i, !bad)
      tick(1);
      `CHK(addr_parity_err_n_oe_o, 1'h0)
   endtask
   initial begin
      #50us;
      err_count++;
      print_verdict();
   end
   initial begin
      tick(12);
      sys_rst_i = 1'h0;
      tick(3);
      `CHK(req_ready_o, 1'h0)
      t_boot(33'h100000036);
      t_own(1'h0, 1'h0, 1'h1);
      t_own(1'h1, 1'h0, 1'h1);
      t_own(1'h0, 1'h1, 1'h1);
      t_snoop(1'h0);
      t_snoop(1'h1);
      t_boot(33'h100000032);
      t_own(1'h0, 1'h1, 1'h0);
      print_verdict();
   end
endmodule
